// file: rxp_port.sv
// receive data output port: i/q nibble stream, if bus, reference clock
//
// Operation
// - every sample leaves in straight binary, zero scale all zeros, full scale all ones.
// - an over-range input clamps the code at full scale or zero scale instead of wrapping.
// - while a frame runs, a new i/q nibble is driven on every rising clock edge; between frames the bus rests at zero.
// - a frame is four nibbles, i high, i low, q high, q low.
// - frame sync is high only with the most significant nibble of i.
// - while the i/q converter is powered down no frame starts, so frame sync stays low in every cycle that follows a powered-down cycle.
// - the if bus is updated once every two clock cycles on alternate falling edges.
// - by default the reference clock output is a buffered copy of the oscillator input.
// - the ref_pwrdn_in pin powers down the internal references, through int_ref_off_out one edge later.
`timescale 1ns/1ps
`include "rxp_params.svh"

module rxp_port
  import rxp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  // converter results, straight binary codes with over/under range flags
  input  wire logic [`RXP_IQ_W-1:0]    i_raw_in,
  input  wire logic [`RXP_IQ_W-1:0]    q_raw_in,
  input  wire logic                    iq_over_in,
  input  wire logic                    iq_under_in,
  input  wire logic                    iq_valid_in,
  output logic                         iq_ready_out,
  input  wire logic [`RXP_IF_W-1:0]    if_raw_in,
  input  wire logic                    if_over_in,
  input  wire logic                    if_under_in,
  // control
  input  wire logic                    iq_pwrdn_in,
  input  wire logic                    ref_pwrdn_in,
  input  wire logic                    oscillator_input,
  input  wire logic                    buffered_osc_out_alt_in,
  input  wire logic                    buffered_osc_out_sel_in,
  // host-facing outputs
  output logic [`RXP_NIB_W-1:0]        iq_nibble_bus,
  output logic                         iq_frame_sync,
  output logic [`RXP_IF_W-1:0]         if_bus_out,
  output logic                         buffered_osc_out,
  output logic                         int_ref_off_out
);

  // ------------------------------------------------------------
  // clamping and input buffer
  // ------------------------------------------------------------
  // clamping picks the rail instead of letting a wrapped code through
  function automatic logic [`RXP_IQ_W-1:0] clamp8(input logic [`RXP_IQ_W-1:0] v,
                                                 input logic ov, input logic un);
    clamp8 = ov ? `RXP_CODE_MAX8 : (un ? 8'h00 : v);
  endfunction

  // two-entry buffer; the pointers toggle, so the depth is fixed at two
  // limitation: the over and under flags are shared, so one flag clamps both i and q
  // a full buffer refuses the offer instead of overwriting the older pair
  logic [2*`RXP_IQ_W-1:0] buf_ff [`RXP_BUF_DEPTH];
  logic [1:0]             cnt_ff;
  logic                   wp_ff;
  logic                   rp_ff;
  wire                    buf_full  = (cnt_ff == 2'h2);
  wire                    buf_empty = (cnt_ff == 2'h0);
  wire [2*`RXP_IQ_W-1:0]  clamped   = {clamp8(i_raw_in, iq_over_in, iq_under_in),
                                       clamp8(q_raw_in, iq_over_in, iq_under_in)};

  // ------------------------------------------------------------
  // nibble sequencer
  // ------------------------------------------------------------
  // nxt_ values are what the flops will hold after the coming edge
  // the word is latched at frame start, so later pushes cannot tear a frame
  rxp_nib_type            nib_ff;
  logic [2*`RXP_IQ_W-1:0] word_ff;
  logic                   active_ff;
  wire                    at_end   = (nib_ff == RXP_NIB_QLO) || !active_ff;
  // a frame is only started with a full word in hand, so frames never tear
  wire                    take     = at_end && !buf_empty && !iq_pwrdn_in;
  wire                    push     = iq_valid_in && !buf_full;
  wire                    pop      = take;
  wire rxp_nib_type       nxt_nib  = take ? RXP_NIB_IHI :
                                     (active_ff && !at_end) ? rxp_nib_type'(nib_ff + 2'h1) :
                                     nib_ff;
  wire [2*`RXP_IQ_W-1:0]  nxt_word = take ? buf_ff[rp_ff] : word_ff;
  wire                    nxt_active = take ? 1'b1 : (at_end ? 1'b0 : active_ff);
  wire [`RXP_NIB_W-1:0]   nxt_nibble = nxt_word[(3 - nxt_nib) * `RXP_NIB_W +: `RXP_NIB_W];

  // buffer bookkeeping; a receiver stall fills it and drops ready
  // ready comes from the next count, so it already falls on the edge
  // that fills the second entry
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_ff       <= 2'h0;
      wp_ff        <= 1'b0;
      rp_ff        <= 1'b0;
      iq_ready_out <= 1'b0;
    end else begin
      if (push) begin
        buf_ff[wp_ff] <= clamped;
        wp_ff         <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff       <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
      iq_ready_out <= (2'(cnt_ff + {1'b0, push} - {1'b0, pop}) != 2'h2);
    end
  end

  // nibble output on each rising edge
  // sync and the first nibble load on the same edge, so they always align
  // a frame in flight runs to its end even if power-down arrives
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      nib_ff        <= RXP_NIB_IHI;
      word_ff       <= 16'h0000;
      active_ff     <= 1'b0;
      iq_nibble_bus <= 4'h0;
      iq_frame_sync <= 1'b0;
    end else begin
      nib_ff        <= nxt_nib;
      word_ff       <= nxt_word;
      active_ff     <= nxt_active;
      iq_nibble_bus <= nxt_active ? nxt_nibble : 4'h0;
      iq_frame_sync <= take;
    end
  end

  // ------------------------------------------------------------
  // if bus, alternate falling edges
  // ------------------------------------------------------------
  // the phase bit starts low after reset, so the first update lands on the
  // second falling edge; the host must not read the bus before then
  // the bus then stands for two full cycles, a wide window for the host
  logic                 if_ph_ff;
  wire [`RXP_IF_W-1:0]  if_clamped = if_over_in ? `RXP_CODE_MAX12 :
                                     (if_under_in ? 12'h000 : if_raw_in);
  always_ff @(negedge clk_in) begin
    if (!nrst_in) begin
      if_ph_ff   <= 1'b0;
      if_bus_out <= 12'h000;
    end else begin
      if_ph_ff <= ~if_ph_ff;
      if (if_ph_ff) begin
        if_bus_out <= if_clamped;
      end
    end
  end

  // ------------------------------------------------------------
  // reference clock and reference power-down
  // ------------------------------------------------------------
  // the copy is registered, so it follows the oscillator one edge late
  // trade-off: every output stays on a flop, at the cost of a copy that
  // can only follow an oscillator level slower than half the clock
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      buffered_osc_out <= 1'b0;
      int_ref_off_out  <= 1'b0;
    end else begin
      buffered_osc_out <= buffered_osc_out_sel_in ? buffered_osc_out_alt_in : oscillator_input;
      int_ref_off_out  <= ref_pwrdn_in;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // frame sync marks only the first nibble and never returns inside a frame
  sync_only_ihi_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iq_frame_sync |=> !iq_frame_sync[*3]) else $error("sync too soon");
  sync_at_ihi_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iq_frame_sync |-> nib_ff == RXP_NIB_IHI) else $error("sync off first nibble");
  // power-down is sampled one edge ahead of the sync that it suppresses
  sync_pwrdn_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(iq_pwrdn_in) |-> !iq_frame_sync) else $error("sync in power-down");
  // a started frame runs its four nibbles in order
  frame_len_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    take |=> (nib_ff == RXP_NIB_IHI) ##1 (nib_ff == RXP_NIB_ILO) ##1 (nib_ff == RXP_NIB_QHI)
    ##1 (nib_ff == RXP_NIB_QLO)) else $error("frame order");
  // the bus follows the latched word: i high, i low, q high, q low
  ihi_nibble_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iq_frame_sync |-> iq_nibble_bus == word_ff[15:12]) else $error("first nibble");
  nibble_order_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iq_frame_sync |=> (iq_nibble_bus == word_ff[11:8]) ##1 (iq_nibble_bus == word_ff[7:4])
    ##1 (iq_nibble_bus == word_ff[3:0])) else $error("nibble order");
  // an idle bus rests at zero, so a host that lost count sees no stale nibble
  idle_bus_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !active_ff |-> iq_nibble_bus == 4'h0) else $error("idle bus not zero");
  // ready is registered buffer room; it may lag after reset but never leads
  ready_room_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iq_ready_out |-> !buf_full) else $error("ready while full");
  // clamped codes land in the buffer at the rail, plain codes pass untouched
  clamp_hi_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (push && iq_over_in) |=> buf_ff[$past(wp_ff)] == 16'hFFFF)
    else $error("no clamp");
  clamp_lo_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (push && iq_under_in && !iq_over_in) |=> buf_ff[$past(wp_ff)] == 16'h0000)
    else $error("no low clamp");
  code_pass_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (push && !iq_over_in && !iq_under_in) |=>
    (buf_ff[$past(wp_ff)][15:8] == $past(i_raw_in))
    && (buf_ff[$past(wp_ff)][7:0] == $past(q_raw_in))) else $error("code altered");
  // reference controls follow their pins one edge late
  ref_pwr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 int_ref_off_out == $past(ref_pwrdn_in)) else $error("ref off lag");
  buffered_osc_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !$past(buffered_osc_out_sel_in) |-> buffered_osc_out == $past(oscillator_input))
    else $error("buffered_osc_out copy");
  // if bus checks run on the falling edge, the domain of the bus itself
  if_hold_a: assert property (@(negedge clk_in) disable iff (!nrst_in)
    !if_ph_ff |=> $stable(if_bus_out)) else $error("if bus changed early");
  if_update_a: assert property (@(negedge clk_in) disable iff (!nrst_in)
    (if_ph_ff && !if_over_in && !if_under_in) |=> if_bus_out == $past(if_raw_in))
    else $error("if bus missed update");
  if_clamp_hi_a: assert property (@(negedge clk_in) disable iff (!nrst_in)
    (if_ph_ff && if_over_in) |=> if_bus_out == 12'hFFF) else $error("if no high clamp");
  if_clamp_lo_a: assert property (@(negedge clk_in) disable iff (!nrst_in)
    (if_ph_ff && if_under_in && !if_over_in) |=> if_bus_out == 12'h000)
    else $error("if no low clamp");
endmodule

// file: rxp_params.svh
// constants for the receive data output port
`ifndef RXP_PARAMS_SVH
`define RXP_PARAMS_SVH
`define RXP_IQ_W        8
`define RXP_IF_W        12
`define RXP_NIB_W       4
`define RXP_NIB_LAST    2'h3
`define RXP_CODE_MAX8   8'hFF
`define RXP_CODE_MAX12  12'hFFF
`define RXP_CFG_REF_ADDR 12'h002
`define RXP_BUF_DEPTH   2
`endif

// file: rxp_pkg.sv
// types for the receive data output port
package rxp_pkg;
  typedef enum logic [1:0] {
    RXP_NIB_IHI,
    RXP_NIB_ILO,
    RXP_NIB_QHI,
    RXP_NIB_QLO
  } rxp_nib_type;
endpackage

// file: rxp_host.sv
// host model: rebuilds i and q bytes from the nibble stream
`timescale 1ns/1ps

module rxp_host (
  // clock
  input  wire logic       clk_in,
  // stream from the port
  input  wire logic [3:0] nib_in,
  input  wire logic       sync_in,
  // rebuilt sample pair, got_out pulses one cycle
  output logic [7:0]      i_out,
  output logic [7:0]      q_out,
  output logic            got_out
);
  logic [1:0]  cnt_ff = 2'h0;
  logic [11:0] acc_ff = 12'h000;
  logic        busy_ff = 1'b0;
  // count four nibbles from the one with sync high; a stray nibble while idle is ignored
  always @(posedge clk_in) begin
    got_out <= 1'b0;
    if (sync_in) begin
      cnt_ff  <= 2'h1;
      acc_ff  <= {8'h00, nib_in};
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      acc_ff <= {acc_ff[7:0], nib_in};
      cnt_ff <= cnt_ff + 2'h1;
      if (cnt_ff == 2'h3) begin
        busy_ff <= 1'b0;
        got_out <= 1'b1;
        i_out   <= acc_ff[11:4];
        q_out   <= {acc_ff[3:0], nib_in};
      end
    end
  end
endmodule

// file: tb_rxp_port.sv
// self-checking bench for the receive data output port
`timescale 1ns/1ps
`define CHK(w,e,g) n_tests++; if ((g)!==(e)) begin $display("wrong value %s exp %h got %h",w,e,g); num_errors++; end

module tb_rxp_port;
  import rxp_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, iq_valid_in = 1'b0, iq_over_in = 1'b0, iq_under_in = 1'b0;
  logic [7:0] i_raw_in = 8'h00, q_raw_in = 8'h00, hi, hq;
  logic [11:0] if_raw_in = 12'h000, if_bus_out;
  logic if_over_in = 1'b0, if_under_in = 1'b0, iq_pwrdn_in = 1'b0, ref_pwrdn_in = 1'b0;
  logic oscillator_input = 1'b0, iq_ready_out, iq_frame_sync, buffered_osc_out, int_ref_off_out;
  logic hgot;
  logic buffered_osc_out_alt_in = 1'b1, buffered_osc_out_sel_in = 1'b0;
  logic [3:0] iq_nibble_bus;
  logic [15:0] exp_q[$];
  int num_errors = 0, n_tests = 0, k;
  always #5 clk_in = ~clk_in;
  rxp_port rxp_port_inst (.clk_in(clk_in), .nrst_in(nrst_in), .i_raw_in(i_raw_in),
    .q_raw_in(q_raw_in), .iq_over_in(iq_over_in), .iq_under_in(iq_under_in),
    .iq_valid_in(iq_valid_in), .iq_ready_out(iq_ready_out), .if_raw_in(if_raw_in),
    .if_over_in(if_over_in), .if_under_in(if_under_in), .iq_pwrdn_in(iq_pwrdn_in),
    .ref_pwrdn_in(ref_pwrdn_in), .oscillator_input(oscillator_input),
    .buffered_osc_out_alt_in(buffered_osc_out_alt_in), .buffered_osc_out_sel_in(buffered_osc_out_sel_in),
    .iq_nibble_bus(iq_nibble_bus), .iq_frame_sync(iq_frame_sync),
    .if_bus_out(if_bus_out), .buffered_osc_out(buffered_osc_out),
    .int_ref_off_out(int_ref_off_out));
  rxp_host rxp_host_inst (.clk_in(clk_in), .nib_in(iq_nibble_bus), .sync_in(iq_frame_sync),
    .i_out(hi), .q_out(hq), .got_out(hgot));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // offer one pair at the current edge and hold it until the edge that takes it
  task automatic send(input logic [7:0] i, q, input logic ov, un);
    int n;
    iq_valid_in <= 1'b1; i_raw_in <= i; q_raw_in <= q; iq_over_in <= ov; iq_under_in <= un;
    n = 0;
    do begin @(posedge clk_in); n++; end while (iq_ready_out !== 1'b1 && n < 50);
    if (iq_ready_out !== 1'b1) begin num_errors++; conclude(); end
    else exp_q.push_back(ov ? 16'hFFFF : un ? 16'h0000 : {i, q});
  endtask
  // a rebuilt pair always matches the oldest note
  always @(posedge clk_in) if (hgot === 1'b1) begin
    if (exp_q.size() == 0) begin `CHK("extra pair", 1'b0, 1'b1) end
    else begin `CHK("iq pair", exp_q.pop_front(), {hi, hq}) end
  end
  initial begin
    void'($urandom(76850));
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    // back-to-back pairs, some driven over or under range
    for (k = 0; k < 12; k++) send(8'($urandom), 8'($urandom), k % 5 == 1, k % 5 == 3);
    iq_valid_in <= 1'b0;
    for (k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk_in);
    if (exp_q.size() > 0) begin num_errors++; conclude(); end
    // power-down with two pairs waiting: sync must stay quiet, the pairs follow later
    iq_pwrdn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    send(8'h5A, 8'hC3, 1'b0, 1'b0);
    send(8'($urandom), 8'($urandom), 1'b0, 1'b0);
    iq_valid_in <= 1'b0;
    for (k = 0; k < 10; k++) begin
      @(posedge clk_in);
      `CHK("sync in pwrdn", 1'b0, iq_frame_sync)
    end
    `CHK("ready when full", 1'b0, iq_ready_out)
    iq_pwrdn_in <= 1'b0;
    for (k = 0; k < 40 && exp_q.size() > 0; k++) @(posedge clk_in);
    if (exp_q.size() > 0) begin num_errors++; conclude(); end
    // if bus: plain, over range, under range; five cycles cover two updates
    for (k = 0; k < 3; k++) begin
      if_raw_in <= 12'($urandom); if_over_in <= (k == 1); if_under_in <= (k == 2);
      repeat (5) @(posedge clk_in);
      `CHK("if bus", k == 1 ? 12'hFFF : k == 2 ? 12'h000 : if_raw_in, if_bus_out)
    end
    // reference clock copy, then the alternate source, and reference power-down bit
    for (k = 0; k < 4; k++) begin
      oscillator_input <= k[0]; ref_pwrdn_in <= k[0];
      buffered_osc_out_sel_in <= k[1]; buffered_osc_out_alt_in <= ~k[0];
      repeat (3) @(posedge clk_in);
      `CHK("osc copy", k[1] ? ~k[0] : k[0], buffered_osc_out)
      `CHK("ref off", k[0], int_ref_off_out)
    end
    conclude();
  end
endmodule
